/* rsp_self_program_control.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Operation
// - store instruction fetched from the application section is ignored
// - from loader_section it may erase or write any page
// - halting choice follows the target address, not the fetch address
// - concurrent_read_area target: core keeps running from halting_area
// - halting_area target: core halted until ST_FIN, released one cycle before flash_erase/flash_write drop
// - concurrent_read_area never readable while programming runs
// - concurrent_area_busy_flag reads one while a concurrent_read_area operation keeps the area blocked
// - loader_section always lies inside halting_area
// - loader boundary from boot_size_fuses, area boundary fixed
// - two independent boot lock sets, application and loader
// - erase and write work on whole pages
// - busy flag set when a concurrent_read_area operation starts
// - concurrent_read_reenable write after completion clears busy flag
// - page buffer load clears the busy flag
module rsp_self_program_control #(
    parameter int ADDR_W      = rsp_pkg::ADDR_W,
    parameter int PAGE_W      = rsp_pkg::PAGE_W,
    parameter int PROG_CYCLES = rsp_pkg::PROG_CYCLES
)(
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // fuses and lock bits
    input  wire logic [1:0]        boot_size_fuses,
    input  wire logic [1:0]        lock_app,
    input  wire logic [1:0]        lock_ldr,
    // core store_program_instruction
    input  wire logic              spm_req,
    input  wire logic [ADDR_W-1:0] spm_pc,
    input  wire logic [ADDR_W-1:0] spm_addr,
    // core control
    output logic                   core_halt,
    output logic                   rww_read_block,
    // flash array
    output logic                   flash_erase,
    output logic                   flash_write,
    output logic                   page_load,
    output logic [ADDR_W-PAGE_W-1:0] flash_page,
    // interrupt
    output logic                   irq
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_CYCLES - 1);
    localparam int PG_W = ADDR_W - PAGE_W;

    if (PROG_CYCLES < 1 || PAGE_W < 1 || PAGE_W >= ADDR_W)
    begin : g_chk
        $error("unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////

    rsp_pkg::rsp_state_t state_q, state_d;

    logic [rsp_pkg::CTRL_W-1:0] ctrl_q;
    logic [rsp_pkg::EV_W-1:0]   ev_stat_q;
    logic [rsp_pkg::EV_W-1:0]   ev_en_q;
    logic [rsp_pkg::EV_W-1:0]   ev_set;
    logic [CNT_W-1:0]           cnt_q;
    logic                       busy_q, busy_d;
    logic                       halt_q;
    logic                       block_q;
    logic                       erase_q;
    logic                       write_q;
    logic                       load_q;
    logic [PG_W-1:0]            page_q;
    logic [31:0]                rdata_q;
    logic                       ready_q;
    logic                       slverr_q;
    logic                       irq_q;

    logic pc_ldr;
    logic pc_hlt;
    logic tgt_ldr;
    logic tgt_hlt;

    rsp_section_map #(
        .ADDR_W        (ADDR_W)
    ) u_pc_map (
        .addr            (spm_pc),
        .boot_size_fuses (boot_size_fuses),
        .in_loader       (pc_ldr),
        .in_halting      (pc_hlt)
    );

    rsp_section_map #(
        .ADDR_W        (ADDR_W)
    ) u_tgt_map (
        .addr            (spm_addr),
        .boot_size_fuses (boot_size_fuses),
        .in_loader       (tgt_ldr),
        .in_halting      (tgt_hlt)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic setup;
    logic wr_acc;
    logic mapped;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && ready_q && pwrite;
    assign mapped = (paddr == rsp_pkg::OFF_CTRL)
                 || (paddr == rsp_pkg::OFF_STATUS)
                 || (paddr == rsp_pkg::OFF_INT_STAT)
                 || (paddr == rsp_pkg::OFF_INT_CLEAR)
                 || (paddr == rsp_pkg::OFF_INT_EN);

    ////////////////////////////////////////////////////////////////////////
    // store instruction decode

    logic cmd_en;
    logic cmd_erase;
    logic cmd_write;
    logic cmd_load;
    logic lock_ok;
    logic spm_idle;
    logic start;
    logic reject;
    logic reen_wr;

    assign cmd_en    = ctrl_q[rsp_pkg::CTRL_EN_BIT];
    assign cmd_erase = cmd_en && ctrl_q[rsp_pkg::CTRL_ERASE_BIT];
    assign cmd_write = cmd_en && ctrl_q[rsp_pkg::CTRL_WRITE_BIT];
    assign cmd_load  = cmd_en && !cmd_erase && !cmd_write;
    // each section has its own lock set
    assign lock_ok   = tgt_ldr ? lock_ldr[rsp_pkg::LOCK_WR_BIT]
                               : lock_app[rsp_pkg::LOCK_WR_BIT];
    assign spm_idle  = spm_req && (state_q == rsp_pkg::ST_IDLE);
    // only a loader fetch may start programming, any page is reachable
    assign start  = spm_idle && pc_ldr && lock_ok
                 && (cmd_erase || cmd_write);
    assign reject = spm_idle && (!pc_ldr
                 || ((cmd_erase || cmd_write) && !lock_ok));
    assign reen_wr = wr_acc && (paddr == rsp_pkg::OFF_CTRL)
                  && pwdata[rsp_pkg::CTRL_REEN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            rsp_pkg::ST_IDLE:
                if (start)
                    state_d = rsp_pkg::ST_PROG;
            rsp_pkg::ST_PROG:
                if (cnt_q == '0)
                    state_d = rsp_pkg::ST_FIN;
            rsp_pkg::ST_FIN:
                state_d = rsp_pkg::ST_IDLE;
            default:
                state_d = rsp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= rsp_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (start)
            cnt_q <= CNT_LOAD;
        else if (state_q == rsp_pkg::ST_PROG && cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    // the set on start wins over any clear in the same cycle
    always_comb
    begin
        busy_d = busy_q;
        if (state_q == rsp_pkg::ST_IDLE && reen_wr)
            busy_d = 1'b0;
        if (spm_idle && pc_ldr && cmd_load)
            busy_d = 1'b0;
        if (start && !tgt_hlt)
            busy_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q  <= 1'b0;
            block_q <= 1'b0;
        end
        else
        begin
            busy_q  <= busy_d;
            // concurrent area stays dark through any operation
            block_q <= busy_d
                    || (state_d != rsp_pkg::ST_IDLE);
        end
    end

    // halting is picked from the target, the core pc plays no part
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halt_q <= 1'b0;
        else if (start)
            halt_q <= tgt_hlt;
        else if (state_q == rsp_pkg::ST_PROG && cnt_q == '0)
            halt_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            erase_q <= 1'b0;
            write_q <= 1'b0;
            page_q  <= '0;
        end
        else if (start)
        begin
            erase_q <= cmd_erase;
            write_q <= cmd_write && !cmd_erase;
            page_q  <= spm_addr[ADDR_W-1:PAGE_W];
        end
        else if (state_d == rsp_pkg::ST_IDLE)
        begin
            erase_q <= 1'b0;
            write_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            load_q <= 1'b0;
        else
            load_q <= spm_idle && pc_ldr && cmd_load;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // control is frozen while an operation runs; the enable drops at its end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= rsp_pkg::CTRL_RESET;
        else if (state_q == rsp_pkg::ST_FIN
              || (spm_idle && pc_ldr && cmd_load))
            ctrl_q <= rsp_pkg::CTRL_RESET;
        else if (wr_acc && paddr == rsp_pkg::OFF_CTRL
              && state_q == rsp_pkg::ST_IDLE)
            ctrl_q <= {1'b0, pwdata[rsp_pkg::CTRL_W-2:0]};
    end

    assign ev_set = {reject, state_q == rsp_pkg::ST_FIN};

    // sticky events: a set in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_stat_q <= rsp_pkg::EV_RESET;
        else if (wr_acc && paddr == rsp_pkg::OFF_INT_CLEAR)
            ev_stat_q <= (ev_stat_q & ~pwdata[rsp_pkg::EV_W-1:0]) | ev_set;
        else
            ev_stat_q <= ev_stat_q | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_en_q <= rsp_pkg::EV_RESET;
        else if (wr_acc && paddr == rsp_pkg::OFF_INT_EN)
            ev_en_q <= pwdata[rsp_pkg::EV_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(ev_stat_q & ev_en_q);
    end

    // read data is latched in the setup cycle, so no access takes a wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q  <= 32'h0000_0000;
            ready_q  <= 1'b0;
            slverr_q <= 1'b0;
        end
        else
        begin
            ready_q  <= 1'b1;
            if (setup)
            begin
                slverr_q <= !mapped;
                rdata_q  <= 32'h0000_0000;
                unique case (paddr)
                    rsp_pkg::OFF_CTRL:
                        rdata_q[rsp_pkg::CTRL_W-1:0] <= ctrl_q;
                    rsp_pkg::OFF_STATUS:
                    begin
                        rdata_q[rsp_pkg::STAT_BUSY_BIT] <= busy_q;
                        rdata_q[rsp_pkg::STAT_HALT_BIT] <= halt_q;
                        rdata_q[rsp_pkg::STAT_ACTIVE_BIT] <=
                            state_q != rsp_pkg::ST_IDLE;
                    end
                    rsp_pkg::OFF_INT_STAT:
                        rdata_q[rsp_pkg::EV_W-1:0] <= ev_stat_q;
                    rsp_pkg::OFF_INT_EN:
                        rdata_q[rsp_pkg::EV_W-1:0] <= ev_en_q;
                    default:
                        rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata         = rdata_q;
    assign pready         = ready_q;
    assign pslverr        = slverr_q;
    assign core_halt      = halt_q;
    assign rww_read_block = block_q;
    assign flash_erase    = erase_q;
    assign flash_write    = write_q;
    assign page_load      = load_q;
    assign flash_page     = page_q;
    assign irq            = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    app_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        spm_idle && !pc_ldr |=> !erase_q && !write_q
            && state_q == rsp_pkg::ST_IDLE)
        else $error("store from application section started an operation");

    any_page_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && cmd_erase |=> erase_q
            && page_q == $past(spm_addr[ADDR_W-1:PAGE_W]))
        else $error("loader erase did not reach the target page");

    halt_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && tgt_hlt |=> halt_q [*8])
        else $error("halting area target did not halt the core");

    run_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && !tgt_hlt |=> !halt_q && busy_q)
        else $error("concurrent area target halted or left busy clear");

    area_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q != rsp_pkg::ST_IDLE |-> block_q)
        else $error("concurrent area readable during programming");

    busy_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == rsp_pkg::OFF_STATUS
            |=> rdata_q[rsp_pkg::STAT_BUSY_BIT] == $past(busy_q))
        else $error("busy flag read back wrong");

    reen_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        reen_wr && state_q == rsp_pkg::ST_IDLE && !spm_req |=> !busy_q)
        else $error("re-enable write left the busy flag set");

    load_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        spm_idle && pc_ldr && cmd_load |=> !busy_q && load_q)
        else $error("page load did not clear the busy flag");

    core_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == rsp_pkg::ST_PROG && cnt_q == '0
            |=> !halt_q && state_q == rsp_pkg::ST_FIN ##1 !block_q || busy_q)
        else $error("core not released at the end of the operation");

    lock_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        spm_idle && pc_ldr && cmd_write && !lock_ok |=> !write_q && !erase_q)
        else $error("locked section was programmed");

    ldr_inside_a: assert property (@(posedge pclk) disable iff (!presetn)
        pc_ldr |-> pc_hlt)
        else $error("loader section outside the halting area");

    halt_op_c: cover property (@(posedge pclk) disable iff (!presetn)
        start && tgt_hlt ##[1:200] state_q == rsp_pkg::ST_FIN);
    run_op_c: cover property (@(posedge pclk) disable iff (!presetn)
        start && !tgt_hlt ##[1:200] reen_wr && !busy_d);
    reject_c: cover property (@(posedge pclk) disable iff (!presetn)
        reject ##2 irq_q);

endmodule

/* rsp_pkg.sv */
package rsp_pkg;

    // flash geometry, word addressed
    localparam int ADDR_W        = 14;
    localparam int PAGE_W        = 6;
    localparam int FLASH_WORDS   = 16384;
    localparam int HALTING_AREA_START    = 14336;
    localparam int LDR_MIN_WORDS = 256;

    // apb register offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_INT_STAT  = 8'h08;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h0c;
    localparam logic [7:0] OFF_INT_EN    = 8'h10;

    // program_store_control_reg fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_WRITE_BIT = 2;
    localparam int CTRL_REEN_BIT  = 4;
    localparam int CTRL_W         = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // status fields
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_HALT_BIT   = 1;
    localparam int STAT_ACTIVE_BIT = 2;

    // interrupt events
    localparam int EV_DONE_BIT   = 0;
    localparam int EV_REJECT_BIT = 1;
    localparam int EV_W          = 2;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;

    // boot lock: bit 0 programmed (zero) forbids self-programming writes
    localparam int LOCK_WR_BIT = 0;

    // page erase / write duration
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS  = 4000000;
    localparam int PROG_CYCLES   =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_FIN  = 2'b11
    } rsp_state_t;

endpackage

/* rsp_section_map.sv */
`timescale 1ns/100ps
module rsp_section_map #(
    parameter int ADDR_W        = rsp_pkg::ADDR_W,
    parameter int FLASH_WORDS   = rsp_pkg::FLASH_WORDS,
    parameter int HALTING_AREA_START    = rsp_pkg::HALTING_AREA_START,
    parameter int LDR_MIN_WORDS = rsp_pkg::LDR_MIN_WORDS
)(
    // address under test
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        boot_size_fuses,
    // classification
    output logic                   in_loader,
    output logic                   in_halting
);

    localparam logic [ADDR_W:0] TOP_W  = (ADDR_W+1)'(FLASH_WORDS);
    localparam logic [ADDR_W:0] MIN_W  = (ADDR_W+1)'(LDR_MIN_WORDS);
    localparam logic [ADDR_W:0] HALTING_AREA_W = (ADDR_W+1)'(HALTING_AREA_START);

    logic [ADDR_W:0] ldr_size;
    logic [ADDR_W:0] ldr_start;

    // all fuse bits unprogrammed give the smallest loader
    always_comb
    begin
        ldr_size  = MIN_W << (~boot_size_fuses);
        ldr_start = TOP_W - ldr_size;
    end

    // loader boundary follows the fuses, halting boundary is fixed
    assign in_loader  = {1'b0, addr} >= ldr_start;
    assign in_halting = {1'b0, addr} >= HALTING_AREA_W;

    // largest loader must still sit inside the halting area
    if (FLASH_WORDS - (LDR_MIN_WORDS << 3) < HALTING_AREA_START)
    begin : g_chk
        $error("loader can reach outside the halting area");
    end

endmodule

/* rsp_core_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// core running loader code and issuing store instructions
module rsp_core_model #(
    parameter int ADDR_W = rsp_pkg::ADDR_W
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // control from the block
    input  wire logic              core_halt,
    input  wire logic              rww_read_block,
    // store instruction
    output logic                   spm_req,
    output logic [ADDR_W-1:0]      spm_pc,
    output logic [ADDR_W-1:0]      spm_addr
);
    initial
    begin
        spm_req  = 1'b0;
        spm_pc   = '0;
        spm_addr = '0;
    end
    ////////////////////////////////////////////////////////////////////
    // a halted core executes nothing, so it waits for release first
    // interrupts stay masked: no vector fetch reaches the area
    task automatic issue(input logic [ADDR_W-1:0] pc, a,
                         output logic ok);
        int n;
        n = 0;
        while ((core_halt === 1'b1 || presetn !== 1'b1) && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        ok = (core_halt !== 1'b1 && presetn === 1'b1);
        @(posedge pclk);
        spm_req  <= 1'b1;
        spm_pc   <= pc;
        spm_addr <= a;
        @(posedge pclk);
        spm_req  <= 1'b0;
        // released lines show the inverse, never a stale value
        spm_pc   <= ~pc;
        spm_addr <= ~a;
    endtask
    ////////////////////////////////////////////////////////////////////
    // blocked area code is used only once the block has cleared
    task automatic use_area(output logic ok);
        int n;
        n = 0;
        while (rww_read_block !== 1'b0 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        ok = (rww_read_block === 1'b0);
    endtask
endmodule

/* test_rww_self_program_control.sv */
`timescale 1ns/100ps
module test_rww_self_program_control;
    // short program time keeps the run brief
    localparam int PC = 8;
    typedef struct packed {
        logic [1:0]  fuses;
        logic [1:0]  la;
        logic [1:0]  ll;
        logic [7:0]  ctrl;
        logic [13:0] pc;
        logic [13:0] addr;
        logic [3:0]  exp;
        logic [1:0]  ev;
    } rsp_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  boot_size_fuses, lock_app, lock_ldr;
    logic        spm_req, core_halt, rww_read_block, irq, sl, ok;
    logic [13:0] spm_pc, spm_addr;
    logic        flash_erase, flash_write, page_load;
    logic [7:0]  flash_page;
    int          err_count, cmp_count, i, hc;
    rsp_row_t    rows [8];
    logic [7:0]  offs [4];

    always #25 pclk = ~pclk;

    rsp_self_program_control #(.PROG_CYCLES(PC)) u_rsp_self_program_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .boot_size_fuses(boot_size_fuses), .lock_app(lock_app),
        .lock_ldr(lock_ldr), .spm_req(spm_req), .spm_pc(spm_pc),
        .spm_addr(spm_addr), .core_halt(core_halt),
        .rww_read_block(rww_read_block), .flash_erase(flash_erase),
        .flash_write(flash_write), .page_load(page_load),
        .flash_page(flash_page), .irq(irq));

    rsp_core_model u_rsp_core_model (
        .pclk(pclk), .presetn(presetn), .core_halt(core_halt),
        .rww_read_block(rww_read_block), .spm_req(spm_req),
        .spm_pc(spm_pc), .spm_addr(spm_addr));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("mismatches=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        q = prdata;
        sl = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            err_count++;
            wrap_up();
        end
    endtask

    // a store that never gets past a halted core ends the run
    task automatic store_program_instruction(input logic [13:0] pc, a);
        logic done;
        u_rsp_core_model.issue(pc, a, done);
        if (done !== 1'b1)
        begin
            err_count++;
            wrap_up();
        end
    endtask

    // counts halted cycles until the array operation ends
    task automatic wait_op(input logic rww);
        int n;
        n = 0;
        hc = 0;
        while ((flash_erase | flash_write) === 1'b1 && n < 100)
        begin
            if (core_halt === 1'b1)
                hc++;
            if (core_halt === 1'b1 || rww)
                chk(rww_read_block, 1'b1);
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 100)
        begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic run_row(input rsp_row_t r);
        logic rww;
        rww = (r.exp != 4'h0) && (r.addr < rsp_pkg::HALTING_AREA_START);
        @(posedge pclk);
        boot_size_fuses <= r.fuses;
        lock_app        <= r.la;
        lock_ldr        <= r.ll;
        apb(1'b1, rsp_pkg::OFF_CTRL, {24'h0, r.ctrl});
        store_program_instruction(r.pc, r.addr);
        #1;
        chk({flash_erase, flash_write, core_halt, rww_read_block},
            r.exp);
        if (r.exp != 4'h0)
            chk(flash_page, r.addr[13:6]);
        wait_op(rww);
        chk(hc, r.exp[1] ? PC : 0);
        chk(core_halt, 1'b0);
        apb(1'b0, rsp_pkg::OFF_INT_STAT, 32'h0);
        chk(q, r.ev);
        chk(irq, 1'b1);
        apb(1'b1, rsp_pkg::OFF_INT_CLEAR, 32'h3);
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        if (rww)
            chk(q[0], 1'b1);
        chk(irq, 1'b0);
        apb(1'b1, rsp_pkg::OFF_CTRL, 32'h10);
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        chk(q[0], 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        boot_size_fuses = 2'h3;
        lock_app = 2'h3;
        lock_ldr = 2'h3;
        err_count = 0;
        cmp_count = 0;
        offs = '{8'h00, 8'h04, 8'h08, 8'h10};
        rows = '{
            '{2'h3, 2'h3, 2'h3, 8'h03, 14'h3f00, 14'h0040, 4'h9, 2'h1},
            '{2'h3, 2'h3, 2'h3, 8'h05, 14'h0100, 14'h0040, 4'h0, 2'h2},
            '{2'h3, 2'h3, 2'h3, 8'h05, 14'h3f00, 14'h3f40, 4'h7, 2'h1},
            '{2'h0, 2'h3, 2'h3, 8'h03, 14'h3800, 14'h37c0, 4'h9, 2'h1},
            '{2'h3, 2'h3, 2'h3, 8'h03, 14'h3800, 14'h0000, 4'h0, 2'h2},
            '{2'h3, 2'h2, 2'h3, 8'h03, 14'h3f00, 14'h0000, 4'h0, 2'h2},
            '{2'h3, 2'h3, 2'h2, 8'h05, 14'h3f00, 14'h0080, 4'h5, 2'h1},
            '{2'h3, 2'h3, 2'h3, 8'h07, 14'h3fc0, 14'h3800, 4'hb, 2'h1}};
        repeat (20) @(posedge pclk);
        chk({core_halt, rww_read_block, flash_erase, flash_write,
             page_load, irq, pready}, 32'h0);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, offs[i], 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk(sl, 1'b1);
        // event while masked, then unmasked, then cleared
        store_program_instruction(14'h0100, 14'h0040);
        apb(1'b0, rsp_pkg::OFF_INT_STAT, 32'h0);
        chk(q, 32'h2);
        chk(irq, 1'b0);
        apb(1'b1, rsp_pkg::OFF_INT_EN, 32'h3);
        apb(1'b0, rsp_pkg::OFF_INT_EN, 32'h0);
        chk(q, 32'h3);
        chk(irq, 1'b1);
        apb(1'b1, rsp_pkg::OFF_INT_CLEAR, 32'h3);
        apb(1'b0, rsp_pkg::OFF_INT_STAT, 32'h0);
        chk(q, 32'h0);
        chk(irq, 1'b0);
        for (i = 0; i < 8; i++)
            run_row(rows[i]);
        // second request and control write while running are ignored
        apb(1'b1, rsp_pkg::OFF_CTRL, 32'h3);
        store_program_instruction(14'h3f00, 14'h0040);
        store_program_instruction(14'h3f00, 14'h0080);
        apb(1'b1, rsp_pkg::OFF_CTRL, 32'h5);
        // control still holds the running command, the write was refused
        apb(1'b0, rsp_pkg::OFF_CTRL, 32'h0);
        chk(q, 32'h3);
        #1;
        chk(flash_page, 8'h01);
        chk(flash_write, 1'b0);
        wait_op(1'b1);
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        chk(q[0], 1'b1);
        // page buffer load clears the busy flag
        apb(1'b1, rsp_pkg::OFF_CTRL, 32'h1);
        store_program_instruction(14'h3f00, 14'h0000);
        #1;
        chk({page_load, flash_erase, flash_write}, 32'h4);
        @(posedge pclk);
        #1;
        chk(page_load, 1'b0);
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        chk(q[0], 1'b0);
        u_rsp_core_model.use_area(ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1)
            wrap_up();
        apb(1'b1, rsp_pkg::OFF_INT_CLEAR, 32'h3);
        // reset in the middle of a halting operation
        apb(1'b1, rsp_pkg::OFF_CTRL, 32'h3);
        store_program_instruction(14'h3f00, 14'h3f40);
        #1;
        chk(core_halt, 1'b1);
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        chk(q, 32'h6);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk({core_halt, rww_read_block, flash_erase, irq}, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rsp_pkg::OFF_STATUS, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule
